/* File: rtl/mcucf_pkg.sv */
// Shared constants and types for the control-flow and timing core.
`default_nettype none
package mcucf_pkg;
	// Program counter shape.
	localparam int PC_W = 15;
	localparam int UPPER_W = 7;

	// Values after reset.
	localparam logic [14:0] PC_RESET  = 15'h0000;
	localparam logic [7:0]  SP_RESET  = 8'h6F;
	localparam logic [7:0]  ACC_RESET = 8'h00;
	localparam logic [2:0]  STEP_RESET = 3'h0;

	// Fixed target of the software trap.
	localparam logic [14:0] TRAP_ADDR = 15'h00FF;

	// Short relative jump displacement biases.
	localparam logic [6:0] REL_NEG = 7'h0F;
	localparam logic [6:0] REL_POS = 7'h11;

	// Opcodes handled with full semantics, except the direct ALU form, which only advances.
	localparam logic [7:0] OP_ROTATE_RIGHT = 8'hB0;
	localparam logic [7:0] OP_ROTATE_LEFT  = 8'hA8;
	localparam logic [7:0] OP_CARRY_SET    = 8'hA1;
	localparam logic [7:0] OP_CARRY_CLEAR  = 8'hA0;
	localparam logic [7:0] OP_SKIP_UNLESS_C = 8'h88;
	localparam logic [7:0] OP_SKIP_IF_C    = 8'h89;
	localparam logic [7:0] OP_POP_ACC      = 8'h8C;
	localparam logic [7:0] OP_PUSH_ACC     = 8'h67;
	localparam logic [7:0] OP_VECTOR       = 8'hB4;
	localparam logic [7:0] OP_LONG_JUMP    = 8'hAC;
	localparam logic [7:0] OP_LONG_CALL    = 8'hAD;
	localparam logic [7:0] OP_INDIRECT_JUMP = 8'hA5;
	localparam logic [7:0] OP_ROM_TABLE    = 8'hA4;
	localparam logic [7:0] OP_RETURN       = 8'h8E;
	localparam logic [7:0] OP_RETURN_SKIP  = 8'h8D;
	localparam logic [7:0] OP_INT_RETURN   = 8'h8F;
	localparam logic [7:0] OP_TRAP         = 8'h00;
	localparam logic [7:0] OP_NOP          = 8'hB8;
	localparam logic [7:0] OP_DIRECT_ALU   = 8'hBD;
	localparam logic [3:0] OPH_ABS_JUMP    = 4'h2;
	localparam logic [3:0] OPH_SHORT_CALL  = 4'h3;

	// Instruction lengths in bytes.
	localparam logic [1:0] BYTES_ONE   = 2'h1;
	localparam logic [1:0] BYTES_TWO   = 2'h2;
	localparam logic [1:0] BYTES_THREE = 2'h3;

	// Instruction durations in instruction cycles.
	localparam logic [2:0] CYC_SINGLE = 3'h1;
	localparam logic [2:0] CYC_DOUBLE = 3'h2;
	localparam logic [2:0] CYC_TRIPLE = 3'h3;
	localparam logic [2:0] CYC_DIRECT = 3'h4;
	localparam logic [2:0] CYC_CALL   = 3'h5;
	localparam logic [2:0] CYC_TRAP   = 3'h7;

	// Sequencer states.
	typedef enum logic [1:0] {
		MCUCF_EXEC = 2'b00,
		MCUCF_SKIP = 2'b01
	} mcucf_state_t;
endpackage : mcucf_pkg
`default_nettype wire

/* File: rtl/mcucf_timing.sv */
// Opcode decoder that gives the byte length and cycle count of an opcode.
`default_nettype none
module mcucf_timing (
	// Opcode under decode.
	input  wire logic [7:0] op_i,
	// Length and duration.
	output logic      [1:0] bytes_o,
	output logic      [2:0] cycles_o
);
	// Classify the opcode; unknown codes count as one byte, one cycle.
	always_comb begin
		bytes_o  = mcucf_pkg::BYTES_ONE;
		cycles_o = mcucf_pkg::CYC_SINGLE;
		case (op_i) inside
			[8'h01:8'h1F], 8'hA4, 8'hA5, 8'hB2, 8'hB3, 8'hB6,
			8'hBA, 8'hBB, 8'hBE, 8'h67, 8'h8C, [8'hC0:8'hCF]: begin
				cycles_o = mcucf_pkg::CYC_TRIPLE;
			end
			[8'h20:8'h2F], 8'h9C, 8'h9D, 8'h9F: begin
				bytes_o  = mcucf_pkg::BYTES_TWO;
				cycles_o = mcucf_pkg::CYC_TRIPLE;
			end
			[8'h30:8'h3F]: begin
				bytes_o  = mcucf_pkg::BYTES_TWO;
				cycles_o = mcucf_pkg::CYC_CALL;
			end
			[8'h90:8'h9B], 8'h9E, 8'h60: begin
				bytes_o  = mcucf_pkg::BYTES_TWO;
				cycles_o = mcucf_pkg::CYC_DOUBLE;
			end
			8'hA2, 8'hA3, 8'hAA, 8'hAB: begin
				cycles_o = mcucf_pkg::CYC_DOUBLE;
			end
			8'hAC, 8'hBD: begin
				bytes_o  = mcucf_pkg::BYTES_THREE;
				cycles_o = mcucf_pkg::CYC_DIRECT;
			end
			8'hAD: begin
				bytes_o  = mcucf_pkg::BYTES_THREE;
				cycles_o = mcucf_pkg::CYC_CALL;
			end
			8'hA9, 8'hBC: begin
				bytes_o  = mcucf_pkg::BYTES_THREE;
				cycles_o = mcucf_pkg::CYC_TRIPLE;
			end
			8'hB4, 8'h8D, 8'h8E, 8'h8F: begin
				cycles_o = mcucf_pkg::CYC_CALL;
			end
			8'h00: begin
				cycles_o = mcucf_pkg::CYC_TRAP;
			end
			default: begin
				bytes_o  = mcucf_pkg::BYTES_ONE;
				cycles_o = mcucf_pkg::CYC_SINGLE;
			end
		endcase
	end
endmodule : mcucf_timing
`default_nettype wire

/* File: rtl/mcucf_core.sv */
// Control-flow sequencer of the 8-bit core: rotates, skips, stack, jumps.
// Summary of operation
// - Rotate right moves carry into bit seven.
// - Rotate left moves carry into bit zero.
// - Carry test skips next when carry clear.
// - Not-carry test skips next when carry set.
// - Pop increments pointer, then loads accumulator.
// - Push writes accumulator, then decrements pointer.
// - Vector loads counter from two vector bytes.
// - Long jump loads full fifteen bit target.
// - Absolute jump replaces low twelve counter bits.
// - Relative jump adds signed short displacement.
// - Long call pushes return, loads full target.
// - Short call pushes return, replaces low bits.
// - Returns pop counter; return-skip skips next.
// - Interrupt return also sets global enable.
// - Trap pushes return, jumps to 0FF.
// - Immediate forms, absolute jump and short call take two bytes, long jump, long call and direct forms three, others one.
// - Most single byte instructions take one cycle.
// - Arithmetic class timing per operand mode.
// - Table load, push, pop take three cycles.
// - Memory loads and exchanges timed per mode.
// - Indirect jump takes low byte from table.
// - Counter is seven upper plus eight lower bits.
`default_nettype none
module mcucf_core (
	// Clock and reset.
	input  wire logic        core_clk_i,
	input  wire logic        rst_i,
	// Program memory, read combinationally from the address.
	output logic      [14:0] prog_addr_o,
	input  wire logic [7:0]  prog_data_i,
	// Data RAM holding the stack.
	output logic      [7:0]  ram_addr_o,
	output logic      [7:0]  ram_wdata_o,
	output logic             ram_we_o,
	input  wire logic [7:0]  ram_rdata_i,
	// Address of the active interrupt vector's upper byte.
	input  wire logic [14:0] vector_addr_i,
	// Visible core state.
	output logic      [7:0]  acc_o,
	output logic             carry_o,
	output logic             half_carry_o,
	output logic             global_interrupt_enable_o,
	output logic      [7:0]  sp_o,
	output logic      [14:0] pc_o,
	output logic             instr_done_o
);
	// Architectural and sequencing state.
	mcucf_pkg::mcucf_state_t state;
	mcucf_pkg::mcucf_state_t next_state;
	logic [14:0] pc;
	logic [14:0] next_pc;
	logic [14:0] fetch_addr;
	logic [14:0] next_fetch_addr;
	logic [7:0]  acc;
	logic [7:0]  next_acc;
	logic        carry;
	logic        next_carry;
	logic        half_carry_flag;
	logic        next_half_carry_flag;
	logic        global_interrupt_enable;
	logic        next_global_interrupt_enable;
	logic [7:0]  sp;
	logic [7:0]  next_sp;
	logic [7:0]  op;
	logic [7:0]  next_op;
	logic [2:0]  step;
	logic [2:0]  next_step;
	logic [7:0]  lo;
	logic [7:0]  next_lo;
	logic [7:0]  hi;
	logic [7:0]  next_hi;
	logic [7:0]  ram_addr;
	logic [7:0]  next_ram_addr;
	logic [7:0]  ram_wdata;
	logic [7:0]  next_ram_wdata;
	logic        ram_we;
	logic        next_ram_we;
	logic        done;
	logic [7:0]  cur_op;
	logic [1:0]  dec_bytes;
	logic [2:0]  dec_cycles;
	logic        last;
	logic [14:0] seq_pc;
	logic [6:0]  rel_disp;

	// The opcode is on the program bus in the first step only.
	assign cur_op = (step == mcucf_pkg::STEP_RESET) ? prog_data_i : op;

	// Byte and cycle count of the current opcode.
	mcucf_timing u_timing (
		.op_i     (cur_op),
		.bytes_o  (dec_bytes),
		.cycles_o (dec_cycles)
	);

	// Final step, next sequential address and jump displacement.
	assign last    = (step == (dec_cycles - 3'h1));
	assign seq_pc  = pc + {13'h0000, dec_bytes};
	assign rel_disp = cur_op[4] ? ({3'h0, cur_op[3:0]} + mcucf_pkg::REL_POS)
	                            : ({3'h0, cur_op[3:0]} - mcucf_pkg::REL_NEG);

	// Next-state logic of the whole sequencer.
	always_comb begin
		next_state      = state;
		next_pc         = pc;
		next_fetch_addr = fetch_addr;
		next_acc        = acc;
		next_carry      = carry;
		next_half_carry_flag = half_carry_flag;
		next_global_interrupt_enable = global_interrupt_enable;
		next_sp         = sp;
		next_op         = op;
		next_step       = step + 3'h1;
		next_lo         = lo;
		next_hi         = hi;
		next_ram_addr   = ram_addr;
		next_ram_wdata  = ram_wdata;
		next_ram_we     = 1'b0;
		done            = 1'b0;
		unique case (state)
			mcucf_pkg::MCUCF_SKIP: begin
				// Step over the skipped instruction in one cycle.
				next_pc         = seq_pc;
				next_fetch_addr = seq_pc;
				next_step       = mcucf_pkg::STEP_RESET;
				next_state      = mcucf_pkg::MCUCF_EXEC;
			end
			mcucf_pkg::MCUCF_EXEC: begin
				if (step == mcucf_pkg::STEP_RESET) begin
					next_op = prog_data_i;
				end
				next_pc = seq_pc;
				if (cur_op[7:4] == mcucf_pkg::OPH_ABS_JUMP) begin
					if (step == 3'h0) next_fetch_addr = pc + 15'h0001;
					if (step == 3'h1) next_lo = prog_data_i;
					if (last) next_pc = {pc[14:12], cur_op[3:0], lo};
				end else if (cur_op[7:4] == mcucf_pkg::OPH_SHORT_CALL) begin
					if (step == 3'h0) begin
						next_fetch_addr = pc + 15'h0001;
						next_ram_addr   = sp;
						next_ram_wdata  = seq_pc[7:0];
						next_ram_we     = 1'b1;
					end
					if (step == 3'h1) begin
						next_lo        = prog_data_i;
						next_ram_addr  = sp - 8'h01;
						next_ram_wdata = {1'b0, seq_pc[14:8]};
						next_ram_we    = 1'b1;
					end
					if (step == 3'h2) next_sp = sp - 8'h02;
					if (last) next_pc = {pc[14:12], cur_op[3:0], lo};
				end else if (cur_op[7:5] == 3'b000 &&
				             cur_op != mcucf_pkg::OP_TRAP) begin
					if (last) next_pc = pc + {{8{rel_disp[6]}}, rel_disp};
				end else begin
					case (cur_op)
						mcucf_pkg::OP_ROTATE_RIGHT: begin
							next_acc   = {carry, acc[7:1]};
							next_carry = acc[0];
						end
						mcucf_pkg::OP_ROTATE_LEFT: begin
							next_acc   = {acc[6:0], carry};
							next_carry = acc[7];
						end
						mcucf_pkg::OP_CARRY_SET: begin
							next_carry           = 1'b1;
							next_half_carry_flag = 1'b1;
						end
						mcucf_pkg::OP_CARRY_CLEAR: begin
							next_carry           = 1'b0;
							next_half_carry_flag = 1'b0;
						end
						mcucf_pkg::OP_SKIP_UNLESS_C: begin
							if (!carry) next_state = mcucf_pkg::MCUCF_SKIP;
						end
						mcucf_pkg::OP_SKIP_IF_C: begin
							if (carry) next_state = mcucf_pkg::MCUCF_SKIP;
						end
						mcucf_pkg::OP_PUSH_ACC: begin
							if (step == 3'h0) begin
								next_ram_addr  = sp;
								next_ram_wdata = acc;
								next_ram_we    = 1'b1;
							end
							if (step == 3'h1) next_sp = sp - 8'h01;
						end
						mcucf_pkg::OP_POP_ACC: begin
							if (step == 3'h0) begin
								next_sp       = sp + 8'h01;
								next_ram_addr = sp + 8'h01;
							end
							if (step == 3'h1) next_acc = ram_rdata_i;
						end
						mcucf_pkg::OP_ROM_TABLE, mcucf_pkg::OP_INDIRECT_JUMP: begin
							// Table address is the upper part joined to A.
							if (step == 3'h0) next_fetch_addr = {pc[14:8], acc};
							if (step == 3'h1) begin
								if (cur_op == mcucf_pkg::OP_ROM_TABLE) begin
									next_acc = prog_data_i;
								end else begin
									next_lo = prog_data_i;
								end
							end
							if (last && cur_op == mcucf_pkg::OP_INDIRECT_JUMP) begin
								next_pc = {pc[14:8], lo};
							end
						end
						mcucf_pkg::OP_VECTOR: begin
							if (step == 3'h0) next_fetch_addr = vector_addr_i;
							if (step == 3'h1) begin
								next_hi         = prog_data_i;
								next_fetch_addr = fetch_addr + 15'h0001;
							end
							if (step == 3'h2) next_lo = prog_data_i;
							if (last) next_pc = {hi[6:0], lo};
						end
						mcucf_pkg::OP_LONG_JUMP, mcucf_pkg::OP_LONG_CALL: begin
							if (step == 3'h0) next_fetch_addr = pc + 15'h0001;
							if (step == 3'h1) begin
								next_hi         = prog_data_i;
								next_fetch_addr = pc + 15'h0002;
							end
							if (step == 3'h2) next_lo = prog_data_i;
							if (cur_op == mcucf_pkg::OP_LONG_CALL) begin
								if (step == 3'h1) begin
									next_ram_addr  = sp;
									next_ram_wdata = seq_pc[7:0];
									next_ram_we    = 1'b1;
								end
								if (step == 3'h2) begin
									next_ram_addr  = sp - 8'h01;
									next_ram_wdata = {1'b0, seq_pc[14:8]};
									next_ram_we    = 1'b1;
								end
								if (step == 3'h3) next_sp = sp - 8'h02;
							end
							if (last) next_pc = {hi[6:0], lo};
						end
						mcucf_pkg::OP_TRAP: begin
							if (step == 3'h0) begin
								next_ram_addr  = sp;
								next_ram_wdata = seq_pc[7:0];
								next_ram_we    = 1'b1;
							end
							if (step == 3'h1) begin
								next_ram_addr  = sp - 8'h01;
								next_ram_wdata = {1'b0, seq_pc[14:8]};
								next_ram_we    = 1'b1;
							end
							if (step == 3'h2) next_sp = sp - 8'h02;
							if (last) next_pc = mcucf_pkg::TRAP_ADDR;
						end
						mcucf_pkg::OP_RETURN, mcucf_pkg::OP_RETURN_SKIP,
						mcucf_pkg::OP_INT_RETURN: begin
							if (step == 3'h0) begin
								next_sp       = sp + 8'h02;
								next_ram_addr = sp + 8'h02;
							end
							if (step == 3'h1) begin
								next_lo       = ram_rdata_i;
								next_ram_addr = sp - 8'h01;
							end
							if (step == 3'h2) next_hi = ram_rdata_i;
							if (last) begin
								next_pc = {hi[6:0], lo};
								if (cur_op == mcucf_pkg::OP_RETURN_SKIP) begin
									next_state = mcucf_pkg::MCUCF_SKIP;
								end
								if (cur_op == mcucf_pkg::OP_INT_RETURN) begin
									next_global_interrupt_enable = 1'b1;
								end
							end
						end
						default: begin
							// Other opcodes only advance by length and duration.
							next_acc = acc;
						end
					endcase
				end
				if (last) begin
					next_fetch_addr = next_pc;
					next_step       = mcucf_pkg::STEP_RESET;
					done            = 1'b1;
				end else begin
					next_pc = pc;
				end
			end
		endcase
	end

	// State registers.
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state      <= mcucf_pkg::MCUCF_EXEC;
			pc         <= mcucf_pkg::PC_RESET;
			fetch_addr <= mcucf_pkg::PC_RESET;
			acc        <= mcucf_pkg::ACC_RESET;
			carry      <= 1'b0;
			half_carry_flag <= 1'b0;
			global_interrupt_enable <= 1'b0;
			sp         <= mcucf_pkg::SP_RESET;
			op         <= mcucf_pkg::ACC_RESET;
			step       <= mcucf_pkg::STEP_RESET;
			lo         <= mcucf_pkg::ACC_RESET;
			hi         <= mcucf_pkg::ACC_RESET;
			ram_addr   <= mcucf_pkg::ACC_RESET;
			ram_wdata  <= mcucf_pkg::ACC_RESET;
			ram_we     <= 1'b0;
		end else begin
			state      <= next_state;
			pc         <= next_pc;
			fetch_addr <= next_fetch_addr;
			acc        <= next_acc;
			carry      <= next_carry;
			half_carry_flag <= next_half_carry_flag;
			global_interrupt_enable <= next_global_interrupt_enable;
			sp         <= next_sp;
			op         <= next_op;
			step       <= next_step;
			lo         <= next_lo;
			hi         <= next_hi;
			ram_addr   <= next_ram_addr;
			ram_wdata  <= next_ram_wdata;
			ram_we     <= next_ram_we;
		end
	end

	// Outputs.
	assign prog_addr_o  = fetch_addr;
	assign ram_addr_o   = ram_addr;
	assign ram_wdata_o  = ram_wdata;
	assign ram_we_o     = ram_we;
	assign acc_o        = acc;
	assign carry_o      = carry;
	assign half_carry_o = half_carry_flag;
	assign global_interrupt_enable_o = global_interrupt_enable;
	assign sp_o         = sp;
	assign pc_o         = pc;
	assign instr_done_o = done;

	// Checks on the sequencer.
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	logic start;
	assign start = (state == mcucf_pkg::MCUCF_EXEC) && (step == 3'h0);
	sequence s_push_pair;
		ram_we ##1 ram_we;
	endsequence
	a_rot_right: assert property (start && prog_data_i == 8'hB0 |=>
		acc == {$past(carry), $past(acc[7:1])} && carry == $past(acc[0]))
		else $error("rotate right result wrong");
	a_rot_left: assert property (start && prog_data_i == 8'hA8 |=>
		acc == {$past(acc[6:0]), $past(carry)} && carry == $past(acc[7]))
		else $error("rotate left result wrong");
	a_carry_skip: assert property (start && prog_data_i == 8'h88
		&& !carry |=> state == mcucf_pkg::MCUCF_SKIP
		##1 state == mcucf_pkg::MCUCF_EXEC)
		else $error("carry test did not skip");
	a_nocarry_skip: assert property (start && prog_data_i == 8'h89
		|=> (state == mcucf_pkg::MCUCF_SKIP) == $past(carry))
		else $error("not-carry test skip wrong");
	a_pop_order: assert property (start && prog_data_i == 8'h8C |=>
		sp == $past(sp) + 8'h01 && ram_addr == sp ##1 acc == $past(ram_rdata_i))
		else $error("pop order wrong");
	a_push_order: assert property (start && prog_data_i == 8'h67 |=>
		ram_we && ram_addr == $past(sp) && ram_wdata == $past(acc)
		##1 sp == $past(sp) - 8'h01)
		else $error("push order wrong");
	a_push_cycles: assert property (start && prog_data_i == 8'h67
		|-> (!done) [*2] ##1 done)
		else $error("push duration wrong");
	a_trap_push: assert property (start && prog_data_i == 8'h00
		|=> s_push_pair ##1 sp == $past(sp, 3) - 8'h02)
		else $error("trap push wrong");
	a_trap_target: assert property (start && prog_data_i == 8'h00
		|-> ##7 pc == mcucf_pkg::TRAP_ADDR && fetch_addr == pc)
		else $error("trap target wrong");
	a_irq_ret_enable: assert property (start && prog_data_i == 8'h8F
		|-> ##5 global_interrupt_enable)
		else $error("interrupt return left enable clear");
	a_set_carry: assert property (start && prog_data_i == 8'hA1
		|=> carry && half_carry_flag)
		else $error("set carry flags wrong");
endmodule : mcucf_core
`default_nettype wire

/* File: verification/mcucf_mem_model.sv */
// Program memory and stack RAM standing beside the core.
`default_nettype none
module mcucf_mem_model (
	// Clock.
	input  wire logic        core_clk_i,
	// Program memory, read without delay.
	input  wire logic [14:0] prog_addr_i,
	output logic      [7:0]  prog_data_o,
	// Stack RAM, read without delay, written on the clock.
	input  wire logic [7:0]  ram_addr_i,
	input  wire logic [7:0]  ram_wdata_i,
	input  wire logic        ram_we_i,
	output logic      [7:0]  ram_rdata_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] rom [0:32767];
	logic [7:0] ram [0:255];

	// Reads follow the address in the same cycle.
	assign prog_data_o = rom[prog_addr_i];
	assign ram_rdata_o = ram[ram_addr_i];

	// A write lands at the edge that ends a strobed cycle.
	always @(posedge core_clk_i) begin
		if (ram_we_i) begin
			ram[ram_addr_i] <= ram_wdata_i;
		end
	end
endmodule : mcucf_mem_model
`default_nettype wire

/* File: verification/mcucf_core_tb.sv */
// Self-checking bench for the control-flow and timing core.
`default_nettype none
module mcucf_core_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic        core_clk_i;
	logic        rst_i;
	logic [14:0] vector_addr_i;
	logic [14:0] prog_addr_o;
	logic [7:0]  prog_data_i;
	logic [7:0]  ram_addr_o;
	logic [7:0]  ram_wdata_o;
	logic        ram_we_o;
	logic [7:0]  ram_rdata_i;
	logic [7:0]  acc_o;
	logic        carry_o;
	logic        half_carry_o;
	logic        global_interrupt_enable_o;
	logic [7:0]  sp_o;
	logic [14:0] pc_o;
	logic        instr_done_o;
	int          err_count;
	int          tests_run;
	logic [7:0]  r;
	logic [7:0]  acc;
	logic [7:0]  w;
	logic [7:0]  v;
	logic [14:0] j;
	logic [14:0] k;
	logic [14:0] a;
	logic [14:0] ct;
	logic [14:0] ra;
	logic [14:0] sj;
	logic [14:0] vt;
	logic [7:0]  prog [17] = '{8'h8C, 8'hA1, 8'hB0, 8'hA0, 8'hA8, 8'h67,
		8'hA1, 8'h88, 8'hA0, 8'h88, 8'hA1, 8'hB8, 8'h89, 8'hA1, 8'h89,
		8'hA0, 8'hB8};

	mcucf_core u_mcucf_core (
		.core_clk_i                (core_clk_i),
		.rst_i                     (rst_i),
		.prog_addr_o               (prog_addr_o),
		.prog_data_i               (prog_data_i),
		.ram_addr_o                (ram_addr_o),
		.ram_wdata_o               (ram_wdata_o),
		.ram_we_o                  (ram_we_o),
		.ram_rdata_i               (ram_rdata_i),
		.vector_addr_i             (vector_addr_i),
		.acc_o                     (acc_o),
		.carry_o                   (carry_o),
		.half_carry_o              (half_carry_o),
		.global_interrupt_enable_o (global_interrupt_enable_o),
		.sp_o                      (sp_o),
		.pc_o                      (pc_o),
		.instr_done_o              (instr_done_o)
	);

	mcucf_mem_model u_mem (
		.core_clk_i  (core_clk_i),
		.prog_addr_i (prog_addr_o),
		.prog_data_o (prog_data_i),
		.ram_addr_i  (ram_addr_o),
		.ram_wdata_i (ram_wdata_o),
		.ram_we_i    (ram_we_o),
		.ram_rdata_o (ram_rdata_i)
	);

	// Free-running core clock of 5 ns.
	initial begin
		core_clk_i = 1'b0;
		forever #2.5 core_clk_i = ~core_clk_i;
	end

	// Prints the counts and the verdict, then stops.
	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_sim

	// Compares one value and counts it.
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Places one program byte.
	task automatic put(input logic [14:0] ad, input logic [7:0] b);
		u_mem.rom[ad] = b;
	endtask : put

	// Runs to the next done pulse and checks the cycles spent.
	task automatic step(input logic [2:0] n);
		int c;
		c = 1;
		while (instr_done_o !== 1'b1 && c <= 20) begin
			@(posedge core_clk_i);
			#1;
			c++;
		end
		chk("cycles", 16'(n), 16'(c));
		if (c > 20) begin
			end_sim();
		end
		@(posedge core_clk_i);
		#1;
	endtask : step

	// Checks a pushed return address and the lowered stack pointer.
	task automatic chk_push(input logic [14:0] ret);
		chk("sp", 16'h006D, 16'(sp_o));
		chk("ram_lo", 16'(ret[7:0]), 16'(u_mem.ram[8'h6F]));
		chk("ram_hi", 16'({1'b0, ret[14:8]}), 16'(u_mem.ram[8'h6E]));
	endtask : chk_push

	// Main sequence: one program that walks every instruction kind except plain return.
	initial begin
		rst_i = 1'b1;
		vector_addr_i = 15'h0000;
		err_count = 0;
		tests_run = 0;
		void'($urandom(32'h7AF16AAD));
		r = 8'($urandom()) | 8'h80;
		acc = {r[7:1], 1'b0};
		j = {1'b1, 14'($urandom())};
		k = {j[14:12], j[11:8] ^ 4'h8, 2'b00, 6'($urandom())};
		w = acc ^ 8'h10;
		v = acc ^ 8'h20;
		a = {k[14:8], v};
		ct = {a[14:12] ^ 3'b010, 12'($urandom())};
		ra = a + 15'h0003;
		sj = {ra[14:12], ra[11:8] ^ 4'h4, 8'($urandom())};
		vt = {3'b011, 12'($urandom())};
		for (int i = 0; i < 32768; i++) begin
			u_mem.rom[i] = 8'hB8;
		end
		for (int i = 0; i < 17; i++) begin
			put(15'(i), prog[i]);
		end
		u_mem.ram[8'h70] = r;
		put(15'h0011, 8'hAC);
		put(15'h0012, {1'b0, j[14:8]});
		put(15'h0013, j[7:0]);
		put(j, {4'h2, k[11:8]});
		put(j + 15'h0001, k[7:0]);
		put(k, 8'h1F);
		put(k + 15'h0020, 8'h01);
		put(k + 15'h0012, 8'hA4);
		put(k + 15'h0013, 8'hA5);
		put({k[14:8], acc}, w);
		put({k[14:8], w}, v);
		put(a, 8'hAD);
		put(a + 15'h0001, {1'b0, ct[14:8]});
		put(a + 15'h0002, ct[7:0]);
		put(ct, 8'h8D);
		put(ra, 8'hA0);
		put(ra + 15'h0001, {4'h3, sj[11:8]});
		put(ra + 15'h0002, sj[7:0]);
		put(sj, 8'h8F);
		put(ra + 15'h0003, 8'h00);
		put(15'h00FF, 8'hBD);
		put(15'h0102, 8'hB4);
		put({7'h10, r}, {1'b0, vt[14:8]});
		put({7'h10, r} + 15'h0001, vt[7:0]);
		put(vt, 8'h94);
		put(vt + 15'h0001, w);
		put(vt + 15'h0002, 8'h84);
		put(vt + 15'h0003, 8'hA2);
		put(vt + 15'h0004, 8'hBE);
		vector_addr_i = {7'h10, r};
		repeat (5) @(posedge core_clk_i);
		#1;
		chk("sp", 16'(mcucf_pkg::SP_RESET), 16'(sp_o));
		chk("pc", 16'h0000, 16'(pc_o));
		rst_i = 1'b0;
		step(3'h3);
		chk("acc", 16'(r), 16'(acc_o));
		chk("sp", 16'h0070, 16'(sp_o));
		step(3'h1);
		chk("half_carry", 16'h0001, 16'(half_carry_o));
		step(3'h1);
		chk("acc", 16'({1'b1, r[7:1]}), 16'(acc_o));
		chk("carry", 16'(r[0]), 16'(carry_o));
		step(3'h1);
		chk("half_carry", 16'h0000, 16'(half_carry_o));
		step(3'h1);
		chk("acc", 16'(acc), 16'(acc_o));
		chk("carry", 16'h0001, 16'(carry_o));
		step(3'h3);
		chk("ram", 16'(acc), 16'(u_mem.ram[8'h70]));
		chk("sp", 16'h006F, 16'(sp_o));
		$display("test rotate and stack done");
		step(3'h1);
		step(3'h1);
		step(3'h1);
		chk("carry", 16'h0000, 16'(carry_o));
		step(3'h1);
		step(3'h2);
		chk("carry", 16'h0000, 16'(carry_o));
		step(3'h1);
		step(3'h1);
		chk("carry", 16'h0001, 16'(carry_o));
		step(3'h1);
		step(3'h2);
		chk("carry", 16'h0001, 16'(carry_o));
		$display("test carry skips done");
		step(3'h4);
		chk("pc", 16'(j), 16'(pc_o));
		step(3'h3);
		chk("pc", 16'(k), 16'(pc_o));
		step(3'h3);
		chk("pc", 16'(k + 15'h0020), 16'(pc_o));
		step(3'h3);
		chk("pc", 16'(k + 15'h0012), 16'(pc_o));
		step(3'h3);
		chk("acc", 16'(w), 16'(acc_o));
		step(3'h3);
		chk("pc", 16'(a), 16'(pc_o));
		$display("test jumps done");
		step(3'h5);
		chk("pc", 16'(ct), 16'(pc_o));
		chk_push(ra);
		step(3'h5);
		chk("pc", 16'(ra), 16'(pc_o));
		chk("sp", 16'h006F, 16'(sp_o));
		step(3'h6);
		chk("carry", 16'h0001, 16'(carry_o));
		chk("pc", 16'(sj), 16'(pc_o));
		chk_push(ra + 15'h0003);
		step(3'h5);
		chk("pc", 16'(ra + 15'h0003), 16'(pc_o));
		chk("int_enable", 16'h0001, 16'(global_interrupt_enable_o));
		step(3'h7);
		chk("pc", 16'h00FF, 16'(pc_o));
		chk_push(ra + 15'h0004);
		$display("test calls and returns done");
		step(3'h4);
		chk("pc", 16'h0102, 16'(pc_o));
		step(3'h5);
		chk("pc", 16'(vt), 16'(pc_o));
		step(3'h2);
		chk("pc", 16'(vt + 15'h0002), 16'(pc_o));
		step(3'h1);
		chk("pc", 16'(vt + 15'h0003), 16'(pc_o));
		step(3'h2);
		chk("pc", 16'(vt + 15'h0004), 16'(pc_o));
		step(3'h3);
		chk("pc", 16'(vt + 15'h0005), 16'(pc_o));
		$display("test vector and timing done");
		end_sim();
	end
endmodule : mcucf_core_tb
`default_nettype wire
